// ==== src/gpb_port_bank.sv ====
// General purpose pin bank: six data groups, per-pin configuration,
// pad drivers, alternate-function muxing and wake/interrupt event status.
// Assumes an Avalon-MM master on MCLK; pads and alternate functions beyond.
//
// Overview of operation
// (R01) Every pin owns one eight-bit configuration register.
// (R02) Config bit 0 is direction, bit 1 polarity, bit 7 driver type.
// (R03) An output pin drives either open-drain or push-pull.
// (R04) Driver type also governs the interrupt-output alternate function.
// (R05) Dir/pol: 00 output, 01 inverted output, 10 input, 11 inverted input.
// (R06) Polarity acts on alternate functions except drive control, joystick, EITHER_EDGE_INTERRUPT.
// (R07) Joystick axis alternate: open-drain, non-inverted, config ignored.
// (R08) Keyboard port and joystick axis alternates are bidirectional.
// (R09) Input data read returns pin level at read time, polarity applied.
// (R10) Writes to data bits of input pins are ignored.
// (R11) Output pins drive the written data bit, inverted by polarity.
// (R12) Output data read returns the last written value.
// (R13) Output pins never feed event or interrupt detection.
// (R14) Polarity picks the status edge; cleared polarity means rising.
// (R15) Event request needs status, pin enable and global enable all set.
// (R16) Event status bits clear on writing one; zero leaves them.
// (R17) Thirty-one pins can raise a wake event.
// (R18) Nineteen pins can raise a management interrupt.
// (R19) Data groups four, five, six sit at indices 4E, 4F, 50.
// (R20) Block base comes from runtime device config registers 60h/61h.
// (R21) Either-edge mode: config has no pin effect; polarity still on reads.
// (R22) Either-edge mode: both pin edges set event and interrupt status.
// (R23) Reserved data bits read zero and ignore writes.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module gpb_port_bank #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RESET,
  // Avalon-MM slave, byte addressed
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // Pads
  input  wire logic [47:0]       PIN_IN,
  output logic      [47:0]       PIN_OUT,
  output logic      [47:0]       PIN_OE,
  // Alternate functions
  input  wire logic [47:0]       ALT_OUT,
  input  wire logic [47:0]       ALT_OE,
  output logic      [47:0]       ALT_IN,
  // Event outputs
  output logic                   EVENT_REQ,
  output logic                   SMI_REQ
);

  localparam int NP = gpb_pkg::PINS;

  // Narrower addresses could not reach the configuration block at index 80h
  generate
    if (ADDR_W < 10) begin : g_bad_addr
      $error("ADDR_W must be at least 10");
    end
    if (NP != gpb_pkg::GROUPS * 8) begin : g_bad_pins
      $error("PINS must fill whole groups");
    end
  endgenerate

  // Bus slave: one wait cycle, answer on the second edge
  logic             ack_reg;
  logic             req;
  logic             hi_ok;
  logic [7:0]       idx;
  logic [7:0]       wb;
  logic             wr_fire;
  logic [31:0]      rd_next;
  logic [31:0]      readdata_reg;

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  // Block base decode sits upstream; only the offset reaches this slave
  assign idx             = AVS_ADDRESS[9:2]; // (R20)
  assign hi_ok           = (ADDR_W == 10) ? 1'b1
                         : ~|(AVS_ADDRESS >> 10);
  assign wb              = AVS_WRITEDATA[7:0];
  // Writes land on the answer edge, never on the first one
  assign wr_fire         = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
  assign AVS_READDATA    = readdata_reg;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Register state
  logic [7:0]    cfg_mem [NP];
  logic [NP-1:0] data_reg;
  logic [NP-1:0] evt_sts_reg;
  logic [NP-1:0] evt_en_reg;
  logic [NP-1:0] smi_sts_reg;
  logic [NP-1:0] smi_en_reg;
  logic          global_en_reg;
  logic          smi_req_reg;
  logic          event_req_reg;

  // Pin synchroniser; stage one is read only by stage two
  // Stages reset low, so a pin held high in reset looks like a rise
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic [NP-1:0] pin_s3;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Per-group write decode
  logic [NP-1:0] wr_data;
  logic [NP-1:0] wr_evt_sts;
  logic [NP-1:0] wr_evt_en;
  logic [NP-1:0] wr_smi_sts;
  logic [NP-1:0] wr_smi_en;
  logic          wr_cfg;
  logic [7:0]    cfg_off;

  always_comb begin
    wr_data    = '0;
    wr_evt_sts = '0;
    wr_evt_en  = '0;
    wr_smi_sts = '0;
    wr_smi_en  = '0;
    for (int g = 0; g < gpb_pkg::GROUPS; g++) begin
      if (wr_fire && hi_ok) begin
        if (idx == gpb_pkg::IDX_DATA_GROUP_ONE + 8'(g)) begin // (R19)
          wr_data[g*8 +: 8] = 8'hFF;
        end
        if (idx == gpb_pkg::IDX_EVT_STS_BASE + 8'(g)) begin
          wr_evt_sts[g*8 +: 8] = wb;
        end
        if (idx == gpb_pkg::IDX_EVT_EN_BASE + 8'(g)) begin
          wr_evt_en[g*8 +: 8] = 8'hFF;
        end
        if (idx == gpb_pkg::IDX_SMI_STS_BASE + 8'(g)) begin
          wr_smi_sts[g*8 +: 8] = wb;
        end
        if (idx == gpb_pkg::IDX_SMI_EN_BASE + 8'(g)) begin
          wr_smi_en[g*8 +: 8] = 8'hFF;
        end
      end
    end
  end

  assign cfg_off = idx - gpb_pkg::IDX_CFG_BASE;
  assign wr_cfg  = wr_fire && hi_ok && idx >= gpb_pkg::IDX_CFG_BASE
                && cfg_off < 8'(NP)
                && gpb_pkg::MASK_VALID[cfg_off[5:0]];

  // Pin view seen by software
  logic [NP-1:0] in_mode;
  logic [NP-1:0] either_edge_interrupt_on;
  logic [NP-1:0] rd_bits;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      global_en_reg <= 1'b0;
    end else if (wr_fire && hi_ok && idx == gpb_pkg::IDX_GLOBAL_EN) begin
      global_en_reg <= wb[gpb_pkg::GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      smi_req_reg   <= 1'b0;
      event_req_reg <= 1'b0;
    end else begin
      smi_req_reg   <= |(smi_sts_reg & smi_en_reg);
      event_req_reg <= global_en_reg & |(evt_sts_reg & evt_en_reg); // (R15)
    end
  end

  assign SMI_REQ   = smi_req_reg;
  assign EVENT_REQ = event_req_reg;

  genvar i;
  generate
    for (i = 0; i < NP; i++) begin : g_pin
      logic [7:0] cfg;
      logic       pol;
      logic       rise;
      logic       fall;
      logic       hit;
      logic       v;
      logic       drv;
      logic       odr;
      logic       ain;
      logic       out_reg;
      logic       oe_reg;
      logic       ain_reg;

      assign cfg        = cfg_mem[i];
      assign pol        = cfg[gpb_pkg::CFG_POL];
      assign either_edge_interrupt_on[i] = gpb_pkg::MASK_EITHER_EDGE_INTERRUPT[i] & cfg[gpb_pkg::CFG_EITHER_EDGE_INTERRUPT];
      assign in_mode[i] = cfg[gpb_pkg::CFG_DIR] | either_edge_interrupt_on[i]; // (R05) (R21)
      // Polarity applies to the read value even in either-edge mode
      assign rd_bits[i] = !gpb_pkg::MASK_VALID[i] ? 1'b0 // (R23)
                        : in_mode[i] ? pin_s2[i] ^ pol // (R09) (R21)
                        : data_reg[i]; // (R12)

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          cfg_mem[i] <= gpb_pkg::CFG_RESET;
        end else if (wr_cfg && cfg_off[5:0] == 6'(i)) begin // (R01) (R02)
          cfg_mem[i] <= wb;
        end
      end

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          data_reg[i] <= gpb_pkg::DATA_RESET[i % 8];
        end else if (wr_data[i] && !in_mode[i]
                     && gpb_pkg::MASK_VALID[i]) begin // (R10) (R23)
          data_reg[i] <= wb[i % 8];
        end
      end

      // Pad and alternate-function mux
      always_comb begin
        v   = 1'b0;
        drv = 1'b0;
        odr = cfg[gpb_pkg::CFG_ODRAIN]; // (R03)
        ain = pin_s2[i] ^ pol; // (R06)
        if (either_edge_interrupt_on[i]) begin
          drv = 1'b0; // (R21)
        end else if (cfg[gpb_pkg::CFG_ALT]) begin
          if (gpb_pkg::MASK_JOY[i]) begin
            v   = ALT_OUT[i]; // (R07)
            drv = ALT_OE[i]; // (R08)
            odr = 1'b1; // (R07)
            ain = pin_s2[i];
          end else if (gpb_pkg::MASK_SMIO[i]) begin
            // Cleared polarity gives an active-low interrupt output
            v   = smi_req_reg ^ ~pol;
            drv = 1'b1; // (R04)
          end else if (gpb_pkg::MASK_DDC[i]) begin
            v   = ALT_OUT[i]; // (R06)
            drv = ALT_OE[i];
            ain = pin_s2[i];
          end else begin
            v   = ALT_OUT[i] ^ pol; // (R06)
            drv = ALT_OE[i]; // (R08)
          end
        end else if (!cfg[gpb_pkg::CFG_DIR]) begin
          v   = data_reg[i] ^ pol; // (R11)
          drv = 1'b1;
        end
      end

      // Open drain only ever pulls low
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          out_reg <= 1'b0;
          oe_reg  <= 1'b0;
          ain_reg <= 1'b0;
        end else begin
          out_reg <= odr ? 1'b0 : v; // (R03)
          oe_reg  <= drv & (odr ? ~v : 1'b1);
          ain_reg <= ain;
        end
      end

      assign PIN_OUT[i] = out_reg;
      assign PIN_OE[i]  = oe_reg;
      assign ALT_IN[i]  = ain_reg;

      // Edge selection; output pins are kept out entirely
      assign rise = pin_s2[i] & ~pin_s3[i];
      assign fall = ~pin_s2[i] & pin_s3[i];
      assign hit  = either_edge_interrupt_on[i] ? (rise | fall) // (R22)
                  : cfg[gpb_pkg::CFG_DIR] & (pol ? fall : rise); // (R13) (R14)

      // Status: a set in the clear cycle wins
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          evt_sts_reg[i] <= 1'b0;
        end else if (gpb_pkg::MASK_WAKE[i] && hit) begin // (R17)
          evt_sts_reg[i] <= 1'b1;
        end else if (wr_evt_sts[i]) begin // (R16)
          evt_sts_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          smi_sts_reg[i] <= 1'b0;
        end else if (gpb_pkg::MASK_SMI[i] && hit) begin // (R18)
          smi_sts_reg[i] <= 1'b1;
        end else if (wr_smi_sts[i]) begin
          smi_sts_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          evt_en_reg[i] <= 1'b0;
          smi_en_reg[i] <= 1'b0;
        end else begin
          if (wr_evt_en[i] && gpb_pkg::MASK_WAKE[i]) begin
            evt_en_reg[i] <= wb[i % 8];
          end
          if (wr_smi_en[i] && gpb_pkg::MASK_SMI[i]) begin
            smi_en_reg[i] <= wb[i % 8];
          end
        end
      end
    end
  endgenerate

  // Read mux; pin levels are caught in the first cycle of the read
  always_comb begin
    rd_next = '0;
    for (int g = 0; g < gpb_pkg::GROUPS; g++) begin
      if (idx == gpb_pkg::IDX_DATA_GROUP_ONE + 8'(g)) begin
        rd_next[7:0] = rd_bits[g*8 +: 8];
      end
      if (idx == gpb_pkg::IDX_EVT_STS_BASE + 8'(g)) begin
        rd_next[7:0] = evt_sts_reg[g*8 +: 8];
      end
      if (idx == gpb_pkg::IDX_EVT_EN_BASE + 8'(g)) begin
        rd_next[7:0] = evt_en_reg[g*8 +: 8];
      end
      if (idx == gpb_pkg::IDX_SMI_STS_BASE + 8'(g)) begin
        rd_next[7:0] = smi_sts_reg[g*8 +: 8];
      end
      if (idx == gpb_pkg::IDX_SMI_EN_BASE + 8'(g)) begin
        rd_next[7:0] = smi_en_reg[g*8 +: 8];
      end
    end
    if (idx == gpb_pkg::IDX_GLOBAL_EN) begin
      rd_next[gpb_pkg::GLOBAL_EN_BIT] = global_en_reg;
    end
    if (idx >= gpb_pkg::IDX_CFG_BASE && cfg_off < 8'(NP)
        && gpb_pkg::MASK_VALID[cfg_off[5:0]]) begin
      rd_next[7:0] = cfg_mem[cfg_off[5:0]];
    end
    if (!hi_ok) begin
      rd_next = '0;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      readdata_reg <= '0;
    end else if (AVS_READ && !ack_reg) begin // (R09)
      readdata_reg <= rd_next;
    end
  end

endmodule // gpb_port_bank

`default_nettype wire

// ==== src/gpb_pkg.sv ====
// Constants for the general purpose pin bank: register indices, config
// field positions, reset values and per-pin capability masks.
// Assumes pin n of group g sits at bit (g-1)*8+n of every 48-bit vector.
package gpb_pkg;

  localparam int PINS   = 48;
  localparam int GROUPS = 6;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA_GROUP_ONE   = 8'h4B;
  localparam logic [7:0] IDX_DATA_GROUP_FOUR  = 8'h4E;
  localparam logic [7:0] IDX_DATA_GROUP_FIVE  = 8'h4F;
  localparam logic [7:0] IDX_DATA_GROUP_SIX   = 8'h50;
  localparam logic [7:0] IDX_EVT_STS_BASE     = 8'h60;
  localparam logic [7:0] IDX_EVT_EN_BASE      = 8'h68;
  localparam logic [7:0] IDX_SMI_STS_BASE     = 8'h70;
  localparam logic [7:0] IDX_SMI_EN_BASE      = 8'h78;
  localparam logic [7:0] IDX_GLOBAL_EN        = 8'h7F;
  localparam logic [7:0] IDX_CFG_BASE         = 8'h80;

  // Pin configuration fields
  localparam int CFG_DIR    = 0;
  localparam int CFG_POL    = 1;
  localparam int CFG_ALT    = 2;
  localparam int CFG_EITHER_EDGE_INTERRUPT   = 3;
  localparam int CFG_ODRAIN = 7;
  localparam logic [7:0] CFG_RESET  = 8'h01;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int GLOBAL_EN_BIT = 0;

  // Capability masks, group six in the top byte
  localparam logic [47:0] MASK_VALID = 48'h03FF0FFFF7FF;
  localparam logic [47:0] MASK_WAKE  = 48'h03FF0A0FF7FF;
  localparam logic [47:0] MASK_SMI   = 48'h03F00E0F7700;
  localparam logic [47:0] MASK_EITHER_EDGE_INTERRUPT  = 48'h03000A000600;
  localparam logic [47:0] MASK_JOY   = 48'h0000000000F0;
  localparam logic [47:0] MASK_KBC   = 48'h000000000700;
  localparam logic [47:0] MASK_SMIO  = 48'h000000008000;
  localparam logic [47:0] MASK_DDC   = 48'h000008000000;

endpackage

// ==== verif/gpb_port_bank_sva.sv ====
// Checker for the pin bank: bus wait, reserved reads, request causes.
// Sees only the top ports; the bind stands below the module.
`timescale 1ns/1ns
`default_nettype none
module gpb_sva #(
  parameter int ADDR_W = 10
) (
  // Clock, reset and bus
  input wire logic              MCLK,
  input wire logic              RESET,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  // Pads and requests
  input wire logic [47:0]       PIN_IN,
  input wire logic              EVENT_REQ,
  input wire logic              SMI_REQ
);
  logic [47:0] pin_reg;
  logic [3:0]  quiet_reg;
  logic [3:0]  age_reg;
  wire  logic  done = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  wire  logic  wdone = done & AVS_WRITE;
  // A request may only follow a recent write or pad change
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pin_reg   <= '0;
      quiet_reg <= '0;
      age_reg   <= '0;
    end else begin
      pin_reg   <= PIN_IN;
      quiet_reg <= (wdone | (PIN_IN != pin_reg)) ? 4'h0 :
                   quiet_reg + {3'h0, ~&quiet_reg};
      age_reg   <= wdone ? 4'h0 : age_reg + {3'h0, ~&age_reg};
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  chk_wait_once: assert property ($rose(AVS_READ | AVS_WRITE)
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bad wait");
  chk_rsv_four: assert property (done & AVS_READ
    & (AVS_ADDRESS == 10'h138) |-> AVS_READDATA[7:4] == 4'h0)
    else $error("reserved bits set");
  chk_rsv_six: assert property (done & AVS_READ
    & (AVS_ADDRESS == 10'h140) |-> AVS_READDATA[7:2] == 6'h00)
    else $error("reserved bits set");
  chk_unmapped_zero: assert property (done & AVS_READ
    & (AVS_ADDRESS == 10'h040) |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!AVS_READ
    |=> $stable(AVS_READDATA)) else $error("read data moved");
  chk_evt_cause: assert property ($rose(EVENT_REQ)
    |-> quiet_reg <= 4'h6) else $error("event without cause");
  chk_evt_clear: assert property ($fell(EVENT_REQ)
    |-> age_reg <= 4'h2) else $error("event dropped alone");
  chk_smi_cause: assert property ($rose(SMI_REQ)
    |-> quiet_reg <= 4'h6) else $error("interrupt without cause");
  cover property ($rose(EVENT_REQ));
  cover property ($rose(SMI_REQ));
  cover property (wdone & (AVS_ADDRESS == 10'h13C));
endmodule // gpb_sva
bind gpb_port_bank gpb_sva #(.ADDR_W(ADDR_W)) u_gpb_sva (.MCLK(MCLK),
  .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN),
  .EVENT_REQ(EVENT_REQ), .SMI_REQ(SMI_REQ));
`default_nettype wire

// ==== verif/gpb_pads.sv ====
// Pad model: external drivers and a pull-up behind every pin.
// Assumes the bench commands each external driver.
`timescale 1ns/1ns
`default_nettype none
module gpb_pads (
  // Bank side
  input  wire logic [47:0] pin_out,
  input  wire logic [47:0] pin_oe,
  output logic      [47:0] pin_in,
  // External drivers
  input  wire logic [47:0] ext_en,
  input  wire logic [47:0] ext_lvl
);
  // Released open-drain pads float up to the pull-up
  always_comb begin
    for (int p = 0; p < 48; p++) begin
      pin_in[p] = pin_oe[p] ? pin_out[p] : (ext_en[p] ? ext_lvl[p] : 1'b1);
    end
  end
endmodule // gpb_pads
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench: bus tasks, pad model, data and event flows.
// Assumes one wait cycle per access, as the bank answers.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        MCLK, RESET, rd, wr, wq, evt, smi, glob;
  logic [9:0]  addr;
  logic [31:0] wd, rdat;
  logic [47:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
  logic [47:0] ext_en, ext_lvl, dat_m;
  logic [7:0]  cfg_m [48];
  logic [7:0]  v, c;
  int          num_errors, num_checks, cyc, seed;

  gpb_port_bank u_gpb_port_bank (.MCLK(MCLK), .RESET(RESET),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wq), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .ALT_OUT(alt_out), .ALT_OE(alt_oe),
    .ALT_IN(alt_in), .EVENT_REQ(evt), .SMI_REQ(smi));
  gpb_pads u_gpb_pads (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .ext_en(ext_en), .ext_lvl(ext_lvl));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] dat);
    @(posedge MCLK);
    rd   <= ~w;
    wr   <= w;
    addr <= {idx, 2'b00};
    wd   <= {24'h0, dat};
    do @(posedge MCLK); while (wq !== 1'b0);
    v = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic cfg(input int p, input logic [7:0] val);
    cfg_m[p] = val;
    bus(1'b1, gpb_pkg::IDX_CFG_BASE + p[7:0], val);
  endtask

  task automatic wdat(input int g, input logic [7:0] val);
    for (int n = 0; n < 8; n++) begin
      if (!cfg_m[g * 8 + n][0])
        dat_m[g * 8 + n] = val[n];
    end
    bus(1'b1, gpb_pkg::IDX_DATA_GROUP_ONE + g[7:0], val);
  endtask

  function automatic logic [7:0] exp_grp(input int g);
    int p;
    for (int n = 0; n < 8; n++) begin
      p = g * 8 + n;
      if (!gpb_pkg::MASK_VALID[p])
        exp_grp[n] = 1'b0;
      else if (cfg_m[p][0])
        exp_grp[n] = (ext_en[p] ? ext_lvl[p] : 1'b1) ^ cfg_m[p][1];
      else
        exp_grp[n] = dat_m[p];
    end
  endfunction

  // Moves one pad, then checks requests, status and clearing
  task automatic ev(input int p, input logic l, input logic [7:0] s,
                    input logic [7:0] m);
    ext_lvl[p] <= l;
    repeat (6) @(posedge MCLK);
    check({7'h0, evt}, {7'h0, (|m) & glob});
    check({7'h0, smi}, {7'h0, (|m) & (p != 0)});
    bus(1'b0, s, 8'h00);
    check(v, m);
    bus(1'b1, s, 8'h00);
    bus(1'b0, s, 8'h00);
    check(v, m);
    bus(1'b1, s, 8'hFF);
    bus(1'b1, s + 8'h10, 8'hFF);
  endtask

  initial begin
    seed = 32'hb224;
    RESET = 1'b1;
    {rd, wr, addr, wd, glob, dat_m} = '0;
    {alt_out, alt_oe, ext_lvl} = '0;
    ext_en = '1;
    for (int p = 0; p < 48; p++)
      cfg_m[p] = gpb_pkg::CFG_RESET;
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    for (int g = 3; g < 6; g++) begin
      bus(1'b0, gpb_pkg::IDX_DATA_GROUP_ONE + g[7:0], 8'h00);
      check(v, exp_grp(g));
    end
    bus(1'b0, gpb_pkg::IDX_CFG_BASE, 8'h00);
    check(v, gpb_pkg::CFG_RESET);
    bus(1'b0, 8'h10, 8'h00);
    check(v, 8'h00);
    // Every direction, polarity and driver code on one pin
    for (int k = 0; k < 8; k++) begin
      c = {k[2], 5'h0, k[1], k[0]};
      alt_out <= 48'({$random(seed), $random(seed)});
      alt_oe  <= 48'({$random(seed), $random(seed)});
      ext_en[32]  <= k[0];
      ext_lvl[32] <= 1'($random(seed));
      cfg(32, c);
      wdat(4, 8'($random(seed)));
      repeat (4) @(posedge MCLK);
      bus(1'b0, gpb_pkg::IDX_DATA_GROUP_FIVE, 8'h00);
      check(v, exp_grp(4));
      if (!c[0]) begin
        check({7'h0, pin_oe[32]}, {7'h0, ~c[7] | ~(dat_m[32] ^ c[1])});
        check({7'h0, pin_out[32]}, {7'h0, ~c[7] & (dat_m[32] ^ c[1])});
      end else begin
        check({7'h0, alt_in[32]}, {7'h0, ext_lvl[32] ^ c[1]});
      end
    end
    bus(1'b1, gpb_pkg::IDX_EVT_EN_BASE, 8'h01);
    bus(1'b1, gpb_pkg::IDX_EVT_EN_BASE + 8'h01, 8'h02);
    bus(1'b1, gpb_pkg::IDX_SMI_EN_BASE + 8'h01, 8'h02);
    ev(0, 1'b1, gpb_pkg::IDX_EVT_STS_BASE, 8'h01);
    bus(1'b1, gpb_pkg::IDX_GLOBAL_EN, 8'h01);
    glob = 1'b1;
    ev(0, 1'b0, gpb_pkg::IDX_EVT_STS_BASE, 8'h00);
    ev(0, 1'b1, gpb_pkg::IDX_EVT_STS_BASE, 8'h01);
    cfg(0, 8'h03);
    ev(0, 1'b0, gpb_pkg::IDX_EVT_STS_BASE, 8'h01);
    ev(0, 1'b1, gpb_pkg::IDX_EVT_STS_BASE, 8'h00);
    cfg(9, 8'h09);
    ev(9, 1'b1, gpb_pkg::IDX_EVT_STS_BASE + 8'h01, 8'h02);
    ev(9, 1'b0, gpb_pkg::IDX_EVT_STS_BASE + 8'h01, 8'h02);
    // Either-edge pin of group four
    cfg(25, 8'h09);
    bus(1'b1, gpb_pkg::IDX_EVT_EN_BASE + 8'h03, 8'h02);
    bus(1'b1, gpb_pkg::IDX_SMI_EN_BASE + 8'h03, 8'h02);
    ev(25, 1'b1, gpb_pkg::IDX_EVT_STS_BASE + 8'h03, 8'h02);
    ev(25, 1'b0, gpb_pkg::IDX_EVT_STS_BASE + 8'h03, 8'h02);
    // An output pad toggled by its own data sets no status
    ext_en[0] <= 1'b0;
    cfg(0, 8'h00);
    wdat(0, 8'h01);
    ev(0, 1'b0, gpb_pkg::IDX_EVT_STS_BASE, 8'h00);
    // Alternates: joystick axis, keyboard port, interrupt output
    alt_out    <= 48'h000000000010;
    alt_oe     <= 48'h000000000010;
    ext_lvl[4] <= 1'b1;
    cfg(4, 8'h06);
    cfg(8, 8'h06);
    cfg(15, 8'h04);
    repeat (4) @(posedge MCLK);
    check({7'h0, pin_out[4]}, 8'h00);
    check({7'h0, pin_oe[4]}, 8'h00);
    check({7'h0, alt_in[4]}, 8'h01);
    check({7'h0, pin_oe[8]}, 8'h00);
    check({7'h0, alt_in[8]}, 8'h01);
    check({7'h0, pin_out[15]}, 8'h01);
    check({7'h0, pin_oe[15]}, 8'h01);
    cfg(15, 8'h84);
    repeat (2) @(posedge MCLK);
    check({7'h0, pin_oe[15]}, 8'h00);
    check({7'h0, pin_out[15]}, 8'h00);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
